// [ccm_pkg.sv]
// Notes on behaviour
// - With PWM on, bit 7 picks full 16-bit PWM, else shared 8 to 11-bit.
// - Comparator works only while mode bit 6 is set.
// - Rising-edge capture on the pin only while mode bit 5 is set.
// - Falling-edge capture on the pin only while mode bit 4 is set.
// - With bit 3 set, a counter match sets the module flag.
// - With bit 2 set, each counter match inverts the module output pin.
// - Bits 2 and 1 together select frequency output mode.
// - Six 8-bit RW mode registers: 0xda..0xde for modules 0-4, 0xce for 5, page 0.
// - With bit 1 set and bit 2 clear, the module drives a PWM waveform on its pin.
// - Flag raises an interrupt request only while bit 0 is set.
// - While the watchdog is enabled, writes to module 5 mode are ignored.
package ccm_pkg;
  localparam int          NUM_MODULES    = 6;
  localparam int          CNT_W          = 16;
  localparam logic [3:0]  MODE_PAGE      = 4'h0;
  localparam logic [7:0]  ADDR_MODE_M0   = 8'hda;
  localparam logic [7:0]  ADDR_MODE_M1   = 8'hdb;
  localparam logic [7:0]  ADDR_MODE_M2   = 8'hdc;
  localparam logic [7:0]  ADDR_MODE_M3   = 8'hdd;
  localparam logic [7:0]  ADDR_MODE_M4   = 8'hde;
  localparam logic [7:0]  ADDR_MODE_M5   = 8'hce;
  localparam logic [7:0]  MODE_RESET     = 8'h00;
  localparam logic [7:0]  RDATA_UNMAPPED = 8'h00;
  localparam int          WDOG_MODULE    = 5;
  localparam int          BIT_WIDE_PWM   = 7;
  localparam int          BIT_COMP_EN    = 6;
  localparam int          BIT_RISE_CAP   = 5;
  localparam int          BIT_FALL_CAP   = 4;
  localparam int          BIT_MATCH_FLAG = 3;
  localparam int          BIT_TOGGLE     = 2;
  localparam int          BIT_PWM        = 1;
  localparam int          BIT_FLAG_IRQ   = 0;
  localparam int          SHORT_PWM_BASE = 8;
  localparam logic [15:0] CCR_RESET      = 16'h0000;

  typedef enum logic [3:0] {
    OUT_IDLE   = 4'b0001,
    OUT_TOGGLE = 4'b0010,
    OUT_PWM    = 4'b0100,
    OUT_FREQ   = 4'b1000
  } out_mode_t;

  function automatic logic [7:0] mode_addr(input int idx);
    case (idx)
      0:       mode_addr = ADDR_MODE_M0;
      1:       mode_addr = ADDR_MODE_M1;
      2:       mode_addr = ADDR_MODE_M2;
      3:       mode_addr = ADDR_MODE_M3;
      4:       mode_addr = ADDR_MODE_M4;
      default: mode_addr = ADDR_MODE_M5;
    endcase
  endfunction
endpackage

// [ccm_chan_if.sv]
`timescale 1ns/1ps
interface ccm_chan_if;
  logic [7:0]  mode;
  logic [15:0] counter;
  logic        tick;
  logic [1:0]  cycle_sel;
  logic        pin_in;
  logic        ccr_wr;
  logic [15:0] ccr_wdata;
  logic        flag_clr;
  logic        flag;
  logic        irq;
  logic        pin_out;
  logic        pin_oe_n;
  logic [15:0] ccr;

  modport top  (output mode, counter, tick, cycle_sel, pin_in, ccr_wr, ccr_wdata, flag_clr,
                input  flag, irq, pin_out, pin_oe_n, ccr);
  modport chan (input  mode, counter, tick, cycle_sel, pin_in, ccr_wr, ccr_wdata, flag_clr,
                output flag, irq, pin_out, pin_oe_n, ccr);
endinterface

// [ccm_channel.sv]
`timescale 1ns/1ps
module ccm_channel (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic ce_in,
  ccm_chan_if.chan  io
);
  import ccm_pkg::*;

  logic        pin_prev;
  logic        next_pin_prev;
  logic [15:0] next_ccr;
  logic        next_flag;
  logic        next_irq;
  logic        next_pin_out;
  logic        next_pin_oe_n;
  logic [15:0] mask;
  logic        rise;
  logic        fall;
  logic        capture;
  logic        match;
  out_mode_t   out_mode;

  always_comb begin
    // Shared short PWM only compares the low 8..11 counter bits
    if (io.mode[BIT_PWM] && !io.mode[BIT_WIDE_PWM])
      mask = 16'hffff >> (5'd16 - 5'(SHORT_PWM_BASE) - 5'(io.cycle_sel));
    else
      mask = 16'hffff;
    rise    = io.mode[BIT_RISE_CAP] & io.pin_in & ~pin_prev;
    fall    = io.mode[BIT_FALL_CAP] & ~io.pin_in & pin_prev;
    capture = rise | fall;
    match   = io.tick & io.mode[BIT_COMP_EN] & (((io.counter ^ io.ccr) & mask) == 16'h0000);
    case ({io.mode[BIT_TOGGLE], io.mode[BIT_PWM]})
      2'b11:   out_mode = OUT_FREQ;
      2'b01:   out_mode = OUT_PWM;
      2'b10:   out_mode = OUT_TOGGLE;
      default: out_mode = OUT_IDLE;
    endcase
  end

  always_comb begin
    next_pin_prev = io.pin_in;
    next_pin_out  = io.pin_out;
    next_pin_oe_n = 1'b0;
    next_ccr      = io.ccr;
    if (io.ccr_wr)
      next_ccr = io.ccr_wdata;
    // Capture beats a same-cycle software load so no edge is lost
    if (capture)
      next_ccr = io.counter;
    case (out_mode)
      OUT_IDLE: begin
        next_pin_oe_n = 1'b1;
      end
      OUT_TOGGLE: begin
        if (match)
          next_pin_out = ~io.pin_out;
      end
      OUT_PWM: begin
        if (!io.mode[BIT_COMP_EN])
          next_pin_out = 1'b0;
        else if (io.tick)
          next_pin_out = (io.counter & mask) >= (io.ccr & mask);
      end
      OUT_FREQ: begin
        // Low byte steps by the high byte, giving a fixed half period per match
        if (match) begin
          next_pin_out  = ~io.pin_out;
          next_ccr[7:0] = io.ccr[7:0] + io.ccr[15:8];
        end
      end
      default: begin
        next_pin_oe_n = 1'b1;
      end
    endcase
    // A new event wins over a same-cycle clear
    next_flag = capture | (match & io.mode[BIT_MATCH_FLAG]) | (io.flag & ~io.flag_clr);
    next_irq  = next_flag & io.mode[BIT_FLAG_IRQ];
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_prev    <= 1'b0;
      io.ccr      <= CCR_RESET;
      io.flag     <= 1'b0;
      io.irq      <= 1'b0;
      io.pin_out  <= 1'b0;
      io.pin_oe_n <= 1'b1;
    end else if (ce_in) begin
      pin_prev    <= next_pin_prev;
      io.ccr      <= next_ccr;
      io.flag     <= next_flag;
      io.irq      <= next_irq;
      io.pin_out  <= next_pin_out;
      io.pin_oe_n <= next_pin_oe_n;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_rise_seen;
    ce_in && io.mode[BIT_RISE_CAP] && io.pin_in && !pin_prev;
  endsequence
  property p_rise_capture;
    s_rise_seen |=> io.ccr == $past(io.counter) && io.flag;
  endproperty
  a_rise_capture: assert property (p_rise_capture) else $error("rising capture missed");

  property p_fall_capture;
    ce_in && io.mode[BIT_FALL_CAP] && !io.pin_in && pin_prev |=> io.ccr == $past(io.counter) && io.flag;
  endproperty
  a_fall_capture: assert property (p_fall_capture) else $error("falling capture missed");

  property p_no_capture;
    ce_in && !io.mode[BIT_RISE_CAP] && !io.mode[BIT_FALL_CAP] && !io.ccr_wr && out_mode != OUT_FREQ
      |=> io.ccr == $past(io.ccr);
  endproperty
  a_no_capture: assert property (p_no_capture) else $error("capture register changed without cause");

  property p_match_flag;
    // Full-width compare holds whenever the short PWM mask is not in force
    ce_in && io.tick && io.mode[BIT_COMP_EN] && io.mode[BIT_MATCH_FLAG]
      && (io.mode[BIT_WIDE_PWM] || !io.mode[BIT_PWM]) && io.counter == io.ccr |=> io.flag;
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match did not set flag");

  property p_irq_mask;
    ##1 io.irq |-> io.flag && $past(io.mode[BIT_FLAG_IRQ]);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt request while masked");

  property p_pwm_off_no_comp;
    ce_in && io.mode[BIT_PWM] && !io.mode[BIT_TOGGLE] && !io.mode[BIT_COMP_EN] |=> !io.pin_out;
  endproperty
  a_pwm_off_no_comp: assert property (p_pwm_off_no_comp) else $error("pwm output high with comparator off");

  property p_toggle;
    ce_in && out_mode == OUT_TOGGLE && match |=> io.pin_out != $past(io.pin_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin did not toggle on match");
endmodule

// [ccm_top.sv]
`timescale 1ns/1ps
module ccm_top (
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 ce_in,
  input  wire logic [7:0]           sfr_addr_in,
  input  wire logic [3:0]           sfr_page_in,
  input  wire logic                 sfr_wr_in,
  input  wire logic                 sfr_rd_in,
  input  wire logic [7:0]           sfr_wdata_in,
  output      logic [7:0]           sfr_rdata_out,
  input  wire logic                 watchdog_enable_in,
  input  wire logic [15:0]          counter_in,
  input  wire logic                 counter_tick_in,
  input  wire logic [1:0]           cycle_sel_in,
  input  wire logic [5:0]           module_io_pin_in,
  input  wire logic [5:0]           ccr_wr_in,
  input  wire logic [15:0]          ccr_wdata_in,
  input  wire logic [5:0]           flag_clear_in,
  output      logic [5:0]           module_io_pin_out,
  output      logic [5:0]           module_io_pin_oe_n_out,
  output      logic [5:0]           capture_compare_flag_out,
  output      logic [5:0]           irq_req_out,
  output      logic [6*16-1:0]      capture_value_out
);
  import ccm_pkg::*;

  logic [7:0] mode      [NUM_MODULES];
  logic [7:0] next_mode [NUM_MODULES];
  logic [7:0] next_rdata;
  logic       page_ok;
  logic       hit;

  always_comb begin
    page_ok    = (sfr_page_in == MODE_PAGE);
    hit        = 1'b0;
    next_rdata = sfr_rdata_out;
    if (sfr_rd_in)
      next_rdata = RDATA_UNMAPPED;
    for (int i = 0; i < NUM_MODULES; i++) begin
      next_mode[i] = mode[i];
      if (page_ok && sfr_addr_in == mode_addr(i)) begin
        hit = 1'b1;
        if (sfr_rd_in)
          next_rdata = mode[i];
        // Watchdog owns module 5; its mode must not shift under it
        if (sfr_wr_in && !(i == WDOG_MODULE && watchdog_enable_in))
          next_mode[i] = sfr_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < NUM_MODULES; i++)
        mode[i] <= MODE_RESET;
      sfr_rdata_out <= RDATA_UNMAPPED;
    end else if (ce_in) begin
      for (int i = 0; i < NUM_MODULES; i++)
        mode[i] <= next_mode[i];
      sfr_rdata_out <= next_rdata;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_MODULES; g++) begin : gen_chan
      ccm_chan_if chan ();
      assign chan.mode      = mode[g];
      assign chan.counter   = counter_in;
      assign chan.tick      = counter_tick_in;
      assign chan.cycle_sel = cycle_sel_in;
      assign chan.pin_in    = module_io_pin_in[g];
      assign chan.ccr_wr    = ccr_wr_in[g];
      assign chan.ccr_wdata = ccr_wdata_in;
      assign chan.flag_clr  = flag_clear_in[g];
      assign module_io_pin_out[g]        = chan.pin_out;
      assign module_io_pin_oe_n_out[g]   = chan.pin_oe_n;
      assign capture_compare_flag_out[g] = chan.flag;
      assign irq_req_out[g]              = chan.irq;
      assign capture_value_out[g*16 +: 16] = chan.ccr;
      ccm_channel u_chan (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .ce_in     (ce_in),
        .io        (chan.chan)
      );
    end
  endgenerate

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_write_m0;
    ce_in && sfr_wr_in && sfr_page_in == MODE_PAGE && sfr_addr_in == ADDR_MODE_M0
      |=> mode[0] == $past(sfr_wdata_in);
  endproperty
  a_write_m0: assert property (p_write_m0) else $error("module 0 mode write lost");

  property p_read_m4;
    ce_in && sfr_rd_in && sfr_page_in == MODE_PAGE && sfr_addr_in == ADDR_MODE_M4
      |=> sfr_rdata_out == $past(mode[4]);
  endproperty
  a_read_m4: assert property (p_read_m4) else $error("module 4 mode read wrong");

  property p_unmapped;
    ce_in && sfr_rd_in && !hit |=> sfr_rdata_out == RDATA_UNMAPPED;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_wdog_lock;
    watchdog_enable_in |=> mode[WDOG_MODULE] == $past(mode[WDOG_MODULE]);
  endproperty
  a_wdog_lock: assert property (p_wdog_lock) else $error("module 5 mode changed under watchdog");
endmodule

// [ccm_pin_model.sv]
`timescale 1ns/1ps
// Far side of the six module pins; it lets go of a pin while the module drives it
module ccm_pin_model (
  input  wire logic       clk_in,
  input  wire logic       slow_in,
  input  wire logic [5:0] level_in,
  input  wire logic [5:0] dut_pin_in,
  input  wire logic [5:0] dut_oe_n_in,
  output      logic [5:0] wire_out
);
  logic [5:0] near_level;
  logic [5:0] late_level;

  // Slow mode adds a cycle, like a sluggish external source
  always_ff @(posedge clk_in) begin
    near_level <= level_in;
    late_level <= near_level;
  end

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      wire_out[i] = dut_oe_n_in[i] ? (slow_in ? late_level[i] : near_level[i]) : dut_pin_in[i];
    end
  end
endmodule

// [capture_compare_mode_ctrl_bench.sv]
`timescale 1ns/1ps
module capture_compare_mode_ctrl_bench;
  import ccm_pkg::*;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [3:0]  sfr_page_in = 4'h0;
  logic [7:0]  sfr_addr_in = 8'h00;
  logic [7:0]  sfr_wdata_in = 8'h00;
  logic        sfr_wr_in = 1'b0;
  logic        sfr_rd_in = 1'b0;
  logic        wdg_en = 1'b0;
  logic        tick = 1'b0;
  logic        slow = 1'b0;
  logic        ce = 1'b1;
  logic [1:0]  cyc = 2'b00;
  logic [15:0] counter = 16'h0000;
  logic [15:0] ccr_data = 16'h0000;
  logic [5:0]  level = 6'h00;
  logic [5:0]  ccr_wr = 6'h00;
  logic [5:0]  flag_clr = 6'h00;
  logic [5:0]  pin_wire, pin_out, oe_n, flag, irq;
  logic [7:0]  rdata;
  logic [95:0] cap;
  logic [7:0]  adr [6];
  int          fail_count = 0;
  int          check_count = 0;

  always #4 clk_in = ~clk_in;

  ccm_top uut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce), .sfr_addr_in(sfr_addr_in),
    .sfr_page_in(sfr_page_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
    .sfr_rdata_out(rdata), .watchdog_enable_in(wdg_en), .counter_in(counter), .counter_tick_in(tick),
    .cycle_sel_in(cyc), .module_io_pin_in(pin_wire), .ccr_wr_in(ccr_wr), .ccr_wdata_in(ccr_data),
    .flag_clear_in(flag_clr), .module_io_pin_out(pin_out), .module_io_pin_oe_n_out(oe_n),
    .capture_compare_flag_out(flag), .irq_req_out(irq), .capture_value_out(cap));
  ccm_pin_model far (.clk_in(clk_in), .slow_in(slow), .level_in(level), .dut_pin_in(pin_out),
    .dut_oe_n_in(oe_n), .wire_out(pin_wire));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    sfr_page_in  <= pg;
    sfr_addr_in  <= a;
    sfr_wdata_in <= d;
    sfr_wr_in    <= 1'b1;
    @(posedge clk_in);
    sfr_wr_in <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    sfr_page_in <= MODE_PAGE;
    sfr_addr_in <= a;
    sfr_rd_in   <= 1'b1;
    @(posedge clk_in);
    sfr_rd_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk(16'(rdata), 16'(exp));
  endtask

  task automatic load_ccr(input logic [5:0] m, input logic [15:0] d);
    @(posedge clk_in);
    ccr_data <= d;
    ccr_wr   <= m;
    @(posedge clk_in);
    ccr_wr <= 6'h00;
  endtask

  task automatic clr_flag(input logic [5:0] m);
    @(posedge clk_in);
    flag_clr <= m;
    @(posedge clk_in);
    flag_clr <= 6'h00;
  endtask

  // Compare is only evaluated in tick cycles, so one tick per value
  task automatic pulse_tick(input logic [15:0] c);
    @(posedge clk_in);
    counter <= c;
    tick    <= 1'b1;
    @(posedge clk_in);
    tick <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask

  // Bounded wait: a capture that never comes shows up as a flag still low
  task automatic drive_pin(input int m, input logic v, input logic [15:0] c);
    int n;
    @(posedge clk_in);
    counter  <= c;
    level[m] <= v;
    n = 0;
    while (flag[m] !== 1'b1 && n < 8) begin
      @(posedge clk_in);
      n++;
    end
    #1;
  endtask

  task automatic t_regs;
    chk(16'(oe_n), 16'h003f);
    for (int i = 0; i < 6; i++) rdchk(adr[i], MODE_RESET);
    for (int i = 0; i < 6; i++) wr(MODE_PAGE, adr[i], 8'h81 + 8'(i) * 8'h11);
    for (int i = 0; i < 6; i++) rdchk(adr[i], 8'h81 + 8'(i) * 8'h11);
    wr(4'h1, adr[0], 8'h00);
    rdchk(adr[0], 8'h81);
    rdchk(8'hd9, RDATA_UNMAPPED);
    for (int i = 0; i < 6; i++) wr(MODE_PAGE, adr[i], 8'h00);
    $display("test regs done");
  endtask

  task automatic t_wdog;
    @(posedge clk_in);
    wdg_en <= 1'b1;
    wr(MODE_PAGE, ADDR_MODE_M5, 8'h5a);
    rdchk(ADDR_MODE_M5, 8'h00);
    @(posedge clk_in);
    wdg_en <= 1'b0;
    wr(MODE_PAGE, ADDR_MODE_M5, 8'h5a);
    rdchk(ADDR_MODE_M5, 8'h5a);
    wr(MODE_PAGE, ADDR_MODE_M5, 8'h00);
    $display("test watchdog lock done");
  endtask

  task automatic t_capture;
    wr(MODE_PAGE, ADDR_MODE_M0, 8'h21);
    drive_pin(0, 1'b1, 16'h1234);
    chk(16'(flag[0]), 16'h0001);
    chk(cap[15:0], 16'h1234);
    chk(16'(irq[0]), 16'h0001);
    clr_flag(6'h01);
    wr(MODE_PAGE, ADDR_MODE_M0, 8'h10);
    @(posedge clk_in);
    slow <= 1'b1;
    drive_pin(0, 1'b0, 16'h0abc);
    chk(16'(flag[0]), 16'h0001);
    chk(cap[15:0], 16'h0abc);
    chk(16'(irq[0]), 16'h0000);
    clr_flag(6'h01);
    drive_pin(0, 1'b1, 16'h0def);
    chk(16'(flag[0]), 16'h0000);
    chk(cap[15:0], 16'h0abc);
    wr(MODE_PAGE, ADDR_MODE_M0, 8'h00);
    $display("test capture done");
  endtask

  task automatic t_match;
    load_ccr(6'h02, 16'h0042);
    wr(MODE_PAGE, ADDR_MODE_M1, 8'h0c);
    pulse_tick(16'h0042);
    chk(16'(flag[1]), 16'h0000);
    chk(16'(pin_out[1]), 16'h0000);
    wr(MODE_PAGE, ADDR_MODE_M1, 8'h4c);
    pulse_tick(16'h0042);
    chk(16'(flag[1]), 16'h0001);
    chk(16'({pin_out[1], oe_n[1]}), 16'h0002);
    pulse_tick(16'h0041);
    chk(16'(pin_out[1]), 16'h0001);
    pulse_tick(16'h0042);
    chk(16'(pin_out[1]), 16'h0000);
    $display("test match toggle done");
  endtask

  task automatic t_pwm;
    load_ccr(6'h04, 16'h0100);
    wr(MODE_PAGE, ADDR_MODE_M2, 8'hc2);
    pulse_tick(16'h0250);
    chk(16'({pin_out[2], oe_n[2]}), 16'h0002);
    pulse_tick(16'h0050);
    chk(16'(pin_out[2]), 16'h0000);
    wr(MODE_PAGE, ADDR_MODE_M2, 8'h42);
    pulse_tick(16'h0050);
    chk(16'(pin_out[2]), 16'h0001);
    // 11-bit cycle: bit 8 of the compare value now counts
    @(posedge clk_in);
    cyc <= 2'b11;
    pulse_tick(16'h0050);
    chk(16'(pin_out[2]), 16'h0000);
    @(posedge clk_in);
    cyc <= 2'b00;
    $display("test pwm done");
  endtask

  task automatic t_freq;
    load_ccr(6'h08, 16'h1005);
    wr(MODE_PAGE, ADDR_MODE_M3, 8'h46);
    pulse_tick(16'h0005);
    chk(16'({pin_out[3], oe_n[3]}), 16'h0002);
    chk(cap[63:48], 16'h1015);
    $display("test frequency output done");
  endtask

  // A write made while the clock enable is low must leave no trace
  task automatic t_hold;
    @(posedge clk_in);
    ce <= 1'b0;
    wr(MODE_PAGE, ADDR_MODE_M4, 8'h3c);
    @(posedge clk_in);
    ce <= 1'b1;
    rdchk(ADDR_MODE_M4, MODE_RESET);
    $display("test clock enable hold done");
  endtask

  // Modes, flags and capture values are non-zero here, so reset has work to do
  task automatic t_reset;
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk(16'({flag, irq}), 16'h0000);
    chk(16'(oe_n), 16'h003f);
    chk(cap[63:48], CCR_RESET);
    chk(cap[31:16], CCR_RESET);
    resetn_in <= 1'b1;
    for (int i = 0; i < 6; i++) rdchk(adr[i], MODE_RESET);
    $display("test mid-run reset done");
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    adr = '{ADDR_MODE_M0, ADDR_MODE_M1, ADDR_MODE_M2, ADDR_MODE_M3, ADDR_MODE_M4, ADDR_MODE_M5};
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_regs;
    t_wdog;
    t_hold;
    t_capture;
    t_match;
    t_pwm;
    t_freq;
    t_reset;
    final_report;
  end

  // The whole run needs well under 1000 cycles
  initial begin
    #20000;
    fail_count++;
    final_report;
  end
endmodule
